/* rtl/clc_pkg.sv */
// Constants and encodings shared by the configurable logic cell
package clc_pkg;

	// Lookup table shapes
	localparam int LUT4_INPUTS = 4;
	localparam int LUT4_DEPTH  = 16;
	localparam int LUT3_INPUTS = 3;
	localparam int LUT3_DEPTH  = 8;

	// General control inputs feeding the control selectors
	localparam int CTRL_COUNT    = 4;
	localparam int CTRL_SEL_BITS = 2;
	typedef logic [CTRL_SEL_BITS-1:0] clc_ctrl_sel_t;

	// Storage data source selector codes
	typedef logic [1:0] clc_data_sel_t;
	localparam clc_data_sel_t DSEL_LUT_A   = 2'h0;
	localparam clc_data_sel_t DSEL_LUT_B   = 2'h1;
	localparam clc_data_sel_t DSEL_COMBINE = 2'h2;
	localparam clc_data_sel_t DSEL_DIRECT  = 2'h3;

	// Combinational output selector codes
	localparam logic OSEL_LUT     = 1'b0;
	localparam logic OSEL_COMBINE = 1'b1;

	// Combining table input selector codes
	localparam logic CSEL_LUT  = 1'b0;
	localparam logic CSEL_CTRL = 1'b1;

	// Storage set/reset type; reset is the default
	localparam logic SR_TYPE_RESET = 1'b0;
	localparam logic SR_TYPE_SET   = 1'b1;

	// Storage mode
	localparam logic MODE_FLOP  = 1'b0;
	localparam logic MODE_LATCH = 1'b1;

	// Clock polarity per element
	localparam logic CLK_RISING  = 1'b0;
	localparam logic CLK_FALLING = 1'b1;

	// Number of storage elements
	localparam int STORE_COUNT = 2;

endpackage : clc_pkg

/* rtl/clc_store.sv */
// One storage element of the logic cell: flip-flop or latch with set/reset
`timescale 1ns/10ps
module clc_store (
	input  wire logic ref_clk_i,
	input  wire logic reset_i,
	input  wire logic data_i,
	input  wire logic clk_en_i,
	input  wire logic set_reset_i,
	input  wire logic global_init_i,
	input  wire logic active_edge_i,
	input  wire logic gate_open_i,
	input  wire logic latch_mode_i,
	input  wire logic sr_value_i,
	output logic      q_o
);
	import clc_pkg::*;

	logic state_reg;
	logic force_val;
	logic transparent;

	// Set/reset and global init override clock and enable alike
	assign force_val   = set_reset_i | global_init_i;
	assign transparent = (latch_mode_i == MODE_LATCH) & clk_en_i & gate_open_i;

	// Reset stands for configuration load: element comes up at its type value
	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			state_reg <= sr_value_i;
		end else if (force_val) begin
			state_reg <= sr_value_i;
		end else if (clk_en_i) begin
			if (latch_mode_i == MODE_LATCH) begin
				if (gate_open_i) begin
					state_reg <= data_i;
				end
			end else if (active_edge_i) begin
				state_reg <= data_i;
			end
		end
	end

	// Output follows the override at once, so set/reset acts without a clock edge
	always_comb begin
		if (force_val) begin
			q_o = sr_value_i;
		end else if (transparent) begin
			q_o = data_i;
		end else begin
			q_o = state_reg;
		end
	end

endmodule : clc_store

/* rtl/clc_cell.sv */
// Configurable logic cell: three lookup tables, steering and two storage elements
`timescale 1ns/10ps
// Notes on behaviour
// - Two independent sixteen-entry four-input tables
// - Three-input combining table with selectable inputs
// - Tables combine for five-input and wider functions
// - Two storage elements, direct or table fed
// - Shared clock, enable, set/reset and global init
// - Optional latches, transparent while gate low
// - Flip-flops capture on per-element selectable edge
// - Active-high shared enable; low holds each element using it
// - Unconnected enable counts as asserted
// - Set/reset forces configured value at once
// - Per-element set or reset type, reset default
// - Unconnected set/reset stays inactive, not invertible
// - Only two unregistered table outputs leave
// - Four-way selector feeds each storage input
// - Output A lut_a/combine, B lut_b/combine
// - Any control input reaches any internal control
// - Set/reset, direct data double as combine inputs
module clc_cell (
	input  wire logic                           ref_clk_i,
	input  wire logic                           reset_i,
	// Logic inputs
	input  wire logic [clc_pkg::LUT4_INPUTS-1:0] lut_a_inputs_i,
	input  wire logic [clc_pkg::LUT4_INPUTS-1:0] lut_b_inputs_i,
	input  wire logic [clc_pkg::CTRL_COUNT-1:0]  ctrl_inputs_i,
	input  wire logic                           storage_clk_i,
	input  wire logic                           global_init_i,
	// Static configuration
	input  wire logic [clc_pkg::LUT4_DEPTH-1:0]  lut_a_cfg_i,
	input  wire logic [clc_pkg::LUT4_DEPTH-1:0]  lut_b_cfg_i,
	input  wire logic [clc_pkg::LUT3_DEPTH-1:0]  lut_combine_cfg_i,
	input  wire logic                           combine_in0_sel_i,
	input  wire logic                           combine_in2_sel_i,
	input  wire clc_pkg::clc_ctrl_sel_t         clk_en_sel_i,
	input  wire clc_pkg::clc_ctrl_sel_t         set_reset_sel_i,
	input  wire clc_pkg::clc_ctrl_sel_t         direct_sel_i,
	input  wire clc_pkg::clc_ctrl_sel_t         combine_in1_sel_i,
	input  wire logic                           comb_a_sel_i,
	input  wire logic                           comb_b_sel_i,
	input  wire clc_pkg::clc_data_sel_t         store_a_data_sel_i,
	input  wire clc_pkg::clc_data_sel_t         store_b_data_sel_i,
	input  wire logic [clc_pkg::STORE_COUNT-1:0] clk_en_used_i,
	input  wire logic [clc_pkg::STORE_COUNT-1:0] set_reset_used_i,
	input  wire logic [clc_pkg::STORE_COUNT-1:0] clk_invert_i,
	input  wire logic [clc_pkg::STORE_COUNT-1:0] sr_type_i,
	input  wire logic                           latch_mode_i,
	// Results
	output logic                                comb_a_o,
	output logic                                comb_b_o,
	output logic                                store_a_q_o,
	output logic                                store_b_q_o
);
	import clc_pkg::*;

	logic                        lut_a_out;
	logic                        lut_b_out;
	logic                        lut_combine_out;
	logic [LUT3_INPUTS-1:0]      combine_addr;
	logic                        clk_en;
	logic                        set_reset_ctl;
	logic                        direct_data;
	logic                        combine_in1;
	logic [STORE_COUNT-1:0]      clk_en_eff;
	logic [STORE_COUNT-1:0]      set_reset_eff;
	logic [STORE_COUNT-1:0]      sr_value;
	logic [STORE_COUNT-1:0]      active_edge;
	logic [STORE_COUNT-1:0]      gate_open;
	logic                        storage_clk_reg;
	logic                        clk_rise;
	logic                        clk_fall;
	logic                        store_a_data;
	logic                        store_b_data;

	// Control selectors: any general input to any internal control
	assign clk_en        = ctrl_inputs_i[clk_en_sel_i];
	assign set_reset_ctl = ctrl_inputs_i[set_reset_sel_i];
	assign direct_data   = ctrl_inputs_i[direct_sel_i];
	assign combine_in1   = ctrl_inputs_i[combine_in1_sel_i];

	// First-level tables; delay does not depend on the stored function
	assign lut_a_out = lut_a_cfg_i[lut_a_inputs_i];
	assign lut_b_out = lut_b_cfg_i[lut_b_inputs_i];

	// Combining table inputs: bit 0 shares set/reset, bit 2 shares direct data
	assign combine_addr[0] = (combine_in0_sel_i == CSEL_CTRL) ? set_reset_ctl : lut_b_out;
	assign combine_addr[1] = combine_in1;
	assign combine_addr[2] = (combine_in2_sel_i == CSEL_CTRL) ? direct_data : lut_a_out;

	// With both table outputs feeding it, nine inputs reach one result
	assign lut_combine_out = lut_combine_cfg_i[combine_addr];

	// Only two combinational results leave; a third function must be stored
	assign comb_a_o = (comb_a_sel_i == OSEL_COMBINE) ? lut_combine_out : lut_a_out;
	assign comb_b_o = (comb_b_sel_i == OSEL_COMBINE) ? lut_combine_out : lut_b_out;

	// Storage data selectors
	always_comb begin
		unique case (store_a_data_sel_i)
			DSEL_LUT_A:   store_a_data = lut_a_out;
			DSEL_LUT_B:   store_a_data = lut_b_out;
			DSEL_COMBINE: store_a_data = lut_combine_out;
			DSEL_DIRECT:  store_a_data = direct_data;
		endcase
	end

	always_comb begin
		unique case (store_b_data_sel_i)
			DSEL_LUT_A:   store_b_data = lut_a_out;
			DSEL_LUT_B:   store_b_data = lut_b_out;
			DSEL_COMBINE: store_b_data = lut_combine_out;
			DSEL_DIRECT:  store_b_data = direct_data;
		endcase
	end

	// Per-element enable and set/reset; neither is invertible in the cell
	assign clk_en_eff    = ~clk_en_used_i | {STORE_COUNT{clk_en}};
	assign set_reset_eff = set_reset_used_i & {STORE_COUNT{set_reset_ctl}};
	assign sr_value      = sr_type_i;

	// Storage clock sampled as a level; edges found against last cycle's value
	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			storage_clk_reg <= 1'b0;
		end else begin
			storage_clk_reg <= storage_clk_i;
		end
	end

	assign clk_rise = storage_clk_i & ~storage_clk_reg;
	assign clk_fall = ~storage_clk_i & storage_clk_reg;

	// Shared clock line, polarity chosen per element
	genvar g;
	generate
		for (g = 0; g < STORE_COUNT; g++) begin : g_pol
			assign active_edge[g] = (clk_invert_i[g] == CLK_FALLING) ? clk_fall : clk_rise;
			assign gate_open[g]   = ~(storage_clk_i ^ clk_invert_i[g]);
		end
	endgenerate

	clc_store u_store_a (
		.ref_clk_i     (ref_clk_i),
		.reset_i       (reset_i),
		.data_i        (store_a_data),
		.clk_en_i      (clk_en_eff[0]),
		.set_reset_i   (set_reset_eff[0]),
		.global_init_i (global_init_i),
		.active_edge_i (active_edge[0]),
		.gate_open_i   (gate_open[0]),
		.latch_mode_i  (latch_mode_i),
		.sr_value_i    (sr_value[0]),
		.q_o           (store_a_q_o)
	);

	clc_store u_store_b (
		.ref_clk_i     (ref_clk_i),
		.reset_i       (reset_i),
		.data_i        (store_b_data),
		.clk_en_i      (clk_en_eff[1]),
		.set_reset_i   (set_reset_eff[1]),
		.global_init_i (global_init_i),
		.active_edge_i (active_edge[1]),
		.gate_open_i   (gate_open[1]),
		.latch_mode_i  (latch_mode_i),
		.sr_value_i    (sr_value[1]),
		.q_o           (store_b_q_o)
	);

	// Checks

	lut_a_value_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
		(comb_a_sel_i == OSEL_LUT) |-> comb_a_o == lut_a_cfg_i[lut_a_inputs_i])
		else $error("output A does not match first table entry");

	lut_b_value_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
		(comb_b_sel_i == OSEL_LUT) |-> comb_b_o == lut_b_cfg_i[lut_b_inputs_i])
		else $error("output B does not match second table entry");

	combine_wide_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
		(comb_a_sel_i == OSEL_COMBINE && combine_in0_sel_i == CSEL_LUT
		&& combine_in2_sel_i == CSEL_LUT)
		|-> comb_a_o == lut_combine_cfg_i[{lut_a_out, combine_in1, lut_b_out}])
		else $error("wide function result wrong");

	combine_ctrl_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
		(comb_b_sel_i == OSEL_COMBINE && combine_in0_sel_i == CSEL_CTRL
		&& combine_in2_sel_i == CSEL_CTRL)
		|-> comb_b_o == lut_combine_cfg_i[{direct_data, combine_in1, set_reset_ctl}])
		else $error("combining table control inputs wrong");

	enable_default_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
		!clk_en_used_i[1] |-> clk_en_eff[1])
		else $error("unconnected enable not asserted");

	sr_default_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
		!set_reset_used_i[1] && !global_init_i && clk_en_used_i[1] && !clk_en
		&& latch_mode_i == MODE_FLOP ##1 !set_reset_used_i[1] && !global_init_i
		|-> $stable(store_b_q_o))
		else $error("unconnected set/reset disturbed storage");

	sr_force_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
		set_reset_eff[0] |-> store_a_q_o == sr_type_i[0])
		else $error("set/reset did not force element A");

	init_force_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
		global_init_i |-> store_a_q_o == sr_type_i[0] && store_b_q_o == sr_type_i[1])
		else $error("global init did not force both elements");

	init_hold_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
		global_init_i ##1 !global_init_i && !set_reset_eff[0] && !clk_en_eff[0]
		|-> store_a_q_o == sr_type_i[0])
		else $error("element A lost its init value");

	flop_capture_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
		latch_mode_i == MODE_FLOP && clk_en_eff[0] && active_edge[0]
		&& !set_reset_eff[0] && !global_init_i
		|=> (set_reset_eff[0] || global_init_i || store_a_q_o == $past(store_a_data)))
		else $error("flip-flop A missed its clock edge");

	enable_hold_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
		latch_mode_i == MODE_FLOP && !clk_en_eff[0] && !set_reset_eff[0] && !global_init_i
		##1 !set_reset_eff[0] && !global_init_i |-> $stable(store_a_q_o))
		else $error("element A changed with enable low");

	latch_pass_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
		latch_mode_i == MODE_LATCH && clk_en_eff[0] && gate_open[0]
		&& !set_reset_eff[0] && !global_init_i |-> store_a_q_o == store_a_data)
		else $error("latch A not transparent with gate low");

	latch_hold_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
		latch_mode_i == MODE_LATCH && !gate_open[0] && !set_reset_eff[0] && !global_init_i
		##1 latch_mode_i == MODE_LATCH && !gate_open[0] && !set_reset_eff[0]
		&& !global_init_i |-> $stable(store_a_q_o))
		else $error("latch A changed with gate high");

	data_select_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
		store_b_data_sel_i == DSEL_DIRECT && latch_mode_i == MODE_LATCH && clk_en_eff[1]
		&& gate_open[1] && !set_reset_eff[1] && !global_init_i
		|-> store_b_q_o == direct_data)
		else $error("element B not fed from direct data");

	comb_a_mux_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
		(comb_a_sel_i == OSEL_COMBINE) |-> comb_a_o == lut_combine_out)
		else $error("output A does not follow the combining table");

	comb_b_mux_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
		(comb_b_sel_i == OSEL_COMBINE) |-> comb_b_o == lut_combine_out)
		else $error("output B does not follow the combining table");

	sr_force_b_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
		set_reset_eff[1] |-> store_b_q_o == sr_type_i[1])
		else $error("set/reset did not force element B");

	sr_shared_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
		(&set_reset_used_i) && set_reset_ctl
		|-> store_a_q_o == sr_type_i[0] && store_b_q_o == sr_type_i[1])
		else $error("shared set/reset did not reach both elements");

	sr_float_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
		latch_mode_i == MODE_FLOP && !set_reset_used_i[0] && set_reset_ctl
		&& clk_en_eff[0] && active_edge[0] && !global_init_i
		|=> (set_reset_eff[0] || global_init_i || store_a_q_o == $past(store_a_data)))
		else $error("unconnected set/reset blocked a capture");

	init_hold_b_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
		global_init_i ##1 !global_init_i && !set_reset_eff[1] && !clk_en_eff[1]
		|-> store_b_q_o == sr_type_i[1])
		else $error("element B lost its init value");

	flop_capture_b_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
		latch_mode_i == MODE_FLOP && clk_en_eff[1] && active_edge[1]
		&& !set_reset_eff[1] && !global_init_i
		|=> (set_reset_eff[1] || global_init_i || store_b_q_o == $past(store_b_data)))
		else $error("flip-flop B missed its clock edge");

	enable_hold_b_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
		latch_mode_i == MODE_FLOP && !clk_en_eff[1] && !set_reset_eff[1] && !global_init_i
		##1 !set_reset_eff[1] && !global_init_i |-> $stable(store_b_q_o))
		else $error("element B changed with enable low");

	latch_pass_b_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
		latch_mode_i == MODE_LATCH && clk_en_eff[1] && gate_open[1]
		&& !set_reset_eff[1] && !global_init_i |-> store_b_q_o == store_b_data)
		else $error("latch B not transparent with gate open");

	latch_hold_b_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
		latch_mode_i == MODE_LATCH && !gate_open[1] && !set_reset_eff[1] && !global_init_i
		##1 latch_mode_i == MODE_LATCH && !gate_open[1] && !set_reset_eff[1]
		&& !global_init_i |-> $stable(store_b_q_o))
		else $error("latch B changed with gate closed");

	enable_float_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
		latch_mode_i == MODE_FLOP && !clk_en_used_i[0] && !clk_en && active_edge[0]
		&& !set_reset_eff[0] && !global_init_i
		|=> (set_reset_eff[0] || global_init_i || store_a_q_o == $past(store_a_data)))
		else $error("unconnected enable blocked a capture");

	enable_shared_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
		latch_mode_i == MODE_FLOP && (&clk_en_used_i) && !clk_en && !(|set_reset_eff)
		&& !global_init_i ##1 !(|set_reset_eff) && !global_init_i
		|-> $stable(store_a_q_o) && $stable(store_b_q_o))
		else $error("shared enable low did not hold both elements");

	latch_enable_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
		latch_mode_i == MODE_LATCH && !clk_en_eff[0] && !set_reset_eff[0] && !global_init_i
		##1 latch_mode_i == MODE_LATCH && !clk_en_eff[0] && !set_reset_eff[0]
		&& !global_init_i |-> $stable(store_a_q_o))
		else $error("latch A changed with enable low");

	feed_first_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
		store_a_data_sel_i == DSEL_LUT_A && latch_mode_i == MODE_LATCH && clk_en_eff[0]
		&& gate_open[0] && !set_reset_eff[0] && !global_init_i
		|-> store_a_q_o == lut_a_out)
		else $error("element A not fed from first table");

	feed_second_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
		store_a_data_sel_i == DSEL_LUT_B && latch_mode_i == MODE_LATCH && clk_en_eff[0]
		&& gate_open[0] && !set_reset_eff[0] && !global_init_i
		|-> store_a_q_o == lut_b_out)
		else $error("element A not fed from second table");

	feed_combine_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
		store_b_data_sel_i == DSEL_COMBINE && latch_mode_i == MODE_LATCH && clk_en_eff[1]
		&& gate_open[1] && !set_reset_eff[1] && !global_init_i
		|-> store_b_q_o == lut_combine_out)
		else $error("element B not fed from combining table");

	feed_direct_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
		store_a_data_sel_i == DSEL_DIRECT && latch_mode_i == MODE_LATCH && clk_en_eff[0]
		&& gate_open[0] && !set_reset_eff[0] && !global_init_i
		|-> store_a_q_o == direct_data)
		else $error("element A not fed from direct data");

	edge_rise_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
		clk_invert_i[0] == CLK_RISING && $rose(storage_clk_i) |-> active_edge[0])
		else $error("rising storage clock edge not seen by element A");

	edge_fall_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
		clk_invert_i[1] == CLK_FALLING && $fell(storage_clk_i) && !$past(reset_i)
		|-> active_edge[1])
		else $error("falling storage clock edge not seen by element B");

	edge_quiet_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
		!$changed(storage_clk_i) && !$past(reset_i) |-> active_edge == '0)
		else $error("edge seen on a steady storage clock");

endmodule : clc_cell

/* test/clc_fabric_model.sv */
// Fabric-side model that drives the shared storage clock of the cell
`timescale 1ns/10ps
module clc_fabric_model (
	input  wire logic ref_clk_i,
	input  wire logic run_i,
	input  wire logic slow_i,
	output logic      storage_clk_o
);
	logic [1:0] div_reg;
	initial storage_clk_o = 1'b0;
	initial div_reg = 2'h0;
	// Moves only after a falling edge, so every level stands at least one full cycle
	always @(negedge ref_clk_i) begin
		if (!run_i) begin
			storage_clk_o <= 1'b0;
			div_reg       <= 2'h0;
		end else begin
			div_reg <= div_reg + 2'h1;
			if (!slow_i || div_reg == 2'h2) begin
				storage_clk_o <= ~storage_clk_o;
			end
		end
	end
endmodule : clc_fabric_model

/* test/clc_cell_test.sv */
// Self-checking testbench of the configurable logic cell
`timescale 1ns/10ps
module clc_cell_test;
	import clc_pkg::*;
	logic ref_clk_i, reset_i, storage_clk_i, global_init_i, run, slow;
	logic [3:0] lut_a_inputs_i, lut_b_inputs_i, ctrl_inputs_i;
	logic [15:0] lut_a_cfg_i, lut_b_cfg_i;
	logic [7:0] lut_combine_cfg_i;
	logic combine_in0_sel_i, combine_in2_sel_i, comb_a_sel_i, comb_b_sel_i, latch_mode_i;
	clc_ctrl_sel_t clk_en_sel_i, set_reset_sel_i, direct_sel_i, combine_in1_sel_i;
	clc_data_sel_t store_a_data_sel_i, store_b_data_sel_i;
	logic [1:0] clk_en_used_i, set_reset_used_i, clk_invert_i, sr_type_i, st_reg;
	logic comb_a_o, comb_b_o, store_a_q_o, store_b_q_o, prev_clk;
	logic [63:0] v;
	int seed, n_mismatch, n_compared, r;

	clc_cell i_clc_cell (.ref_clk_i, .reset_i, .lut_a_inputs_i, .lut_b_inputs_i,
		.ctrl_inputs_i, .storage_clk_i, .global_init_i, .lut_a_cfg_i, .lut_b_cfg_i,
		.lut_combine_cfg_i, .combine_in0_sel_i, .combine_in2_sel_i, .clk_en_sel_i,
		.set_reset_sel_i, .direct_sel_i, .combine_in1_sel_i, .comb_a_sel_i, .comb_b_sel_i,
		.store_a_data_sel_i, .store_b_data_sel_i, .clk_en_used_i, .set_reset_used_i,
		.clk_invert_i, .sr_type_i, .latch_mode_i, .comb_a_o, .comb_b_o, .store_a_q_o,
		.store_b_q_o);
	clc_fabric_model i_clc_fabric_model (.ref_clk_i(ref_clk_i), .run_i(run), .slow_i(slow),
		.storage_clk_o(storage_clk_i));

	initial begin
		ref_clk_i = 1'b0;
		forever #5 ref_clk_i = ~ref_clk_i;
	end

	function automatic logic cmb();
		logic i0, i1, i2;
		i0 = combine_in0_sel_i ? ctrl_inputs_i[set_reset_sel_i] : lut_b_cfg_i[lut_b_inputs_i];
		i1 = ctrl_inputs_i[combine_in1_sel_i];
		i2 = combine_in2_sel_i ? ctrl_inputs_i[direct_sel_i] : lut_a_cfg_i[lut_a_inputs_i];
		return lut_combine_cfg_i[{i2, i1, i0}];
	endfunction : cmb

	function automatic logic dat(input int i);
		case (i ? store_b_data_sel_i : store_a_data_sel_i)
			DSEL_LUT_A:   return lut_a_cfg_i[lut_a_inputs_i];
			DSEL_LUT_B:   return lut_b_cfg_i[lut_b_inputs_i];
			DSEL_COMBINE: return cmb();
			default:      return ctrl_inputs_i[direct_sel_i];
		endcase
	endfunction : dat

	function automatic logic en(input int i);
		return clk_en_used_i[i] ? ctrl_inputs_i[clk_en_sel_i] : 1'b1;
	endfunction : en

	function automatic logic srv(input int i);
		return set_reset_used_i[i] & ctrl_inputs_i[set_reset_sel_i];
	endfunction : srv

	function automatic logic opn(input int i);
		return storage_clk_i == clk_invert_i[i];
	endfunction : opn

	function automatic logic edg(input int i);
		return clk_invert_i[i] ? (prev_clk & ~storage_clk_i) : (~prev_clk & storage_clk_i);
	endfunction : edg

	function automatic logic expq(input int i);
		if (global_init_i || srv(i)) return sr_type_i[i];
		if (latch_mode_i && en(i) && opn(i)) return dat(i);
		return st_reg[i];
	endfunction : expq

	// Reference storage state, updated on the same edge as the cell
	always @(posedge ref_clk_i) begin
		for (int i = 0; i < 2; i++) begin
			if (reset_i || global_init_i || srv(i)) st_reg[i] <= sr_type_i[i];
			else if (en(i) && (latch_mode_i ? opn(i) : edg(i))) st_reg[i] <= dat(i);
		end
		prev_clk <= reset_i ? 1'b0 : storage_clk_i;
	end

	task automatic check(input string name, input logic seen, input logic exp);
		n_compared++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("[ERR] %s expected %b seen %b", name, exp, seen);
		end
	endtask : check

	task automatic finish_test();
		$display("compared %0d mismatches %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask : finish_test

	initial begin
		seed = 35;
		n_mismatch = 0;
		n_compared = 0;
		reset_i = 1'b1;
		global_init_i = 1'b0;
		run = 1'b0;
		slow = 1'b0;
		{lut_a_inputs_i, lut_b_inputs_i, ctrl_inputs_i} = 12'h000;
		{lut_a_cfg_i, lut_b_cfg_i, lut_combine_cfg_i} = 40'h0;
		{combine_in0_sel_i, combine_in2_sel_i, clk_en_sel_i, set_reset_sel_i} = 6'h00;
		{direct_sel_i, combine_in1_sel_i, comb_a_sel_i, comb_b_sel_i} = 6'h00;
		{store_a_data_sel_i, store_b_data_sel_i, clk_en_used_i, set_reset_used_i} = 8'h00;
		{clk_invert_i, sr_type_i, latch_mode_i} = 5'h00;
		repeat (10) @(posedge ref_clk_i);
		for (r = 0; r < 24; r++) begin
			@(negedge ref_clk_i);
			reset_i = 1'b1;
			v = {$random(seed), $random(seed)};
			{lut_a_cfg_i, lut_b_cfg_i} = v[63:32];
			{lut_combine_cfg_i, combine_in0_sel_i, combine_in2_sel_i, clk_en_sel_i,
				set_reset_sel_i, direct_sel_i, combine_in1_sel_i, comb_a_sel_i, comb_b_sel_i,
				store_a_data_sel_i, store_b_data_sel_i, clk_en_used_i, set_reset_used_i,
				clk_invert_i, sr_type_i, latch_mode_i, run, slow} = v[34:0];
			// Nine-input parity built from all three tables
			if (r == 0) begin
				{lut_a_cfg_i, lut_b_cfg_i, lut_combine_cfg_i} = 40'h6996_6996_96;
				{combine_in0_sel_i, combine_in2_sel_i, comb_a_sel_i, run} = 4'h3;
			end
			// Latches with enable and set/reset left unconnected
			if (r == 1) {latch_mode_i, clk_en_used_i, set_reset_used_i, run} = 6'h21;
			@(negedge ref_clk_i);
			reset_i = 1'b0;
			repeat (60) begin
				@(negedge ref_clk_i);
				check("comb_a", comb_a_o, comb_a_sel_i ? cmb() : lut_a_cfg_i[lut_a_inputs_i]);
				check("comb_b", comb_b_o, comb_b_sel_i ? cmb() : lut_b_cfg_i[lut_b_inputs_i]);
				check("store_a", store_a_q_o, expq(0));
				check("store_b", store_b_q_o, expq(1));
				v[11:0] = 12'($random(seed));
				{lut_a_inputs_i, lut_b_inputs_i, ctrl_inputs_i} = v[11:0];
				// Keep set/reset mostly quiet so that captures get a chance
				if (($random(seed) & 3) != 0) ctrl_inputs_i[set_reset_sel_i] = 1'b0;
				global_init_i = ($random(seed) & 15) == 0;
			end
		end
		finish_test();
	end

	initial begin
		repeat (5000) @(posedge ref_clk_i);
		n_mismatch++;
		finish_test();
	end
endmodule : clc_cell_test
